// ==== fmt_chk_defines.svh ====
`ifndef FMT_CHK_DEFINES_SVH
`define FMT_CHK_DEFINES_SVH
`define FMT_REG_BLK_LEN 8'h00
`define FMT_REG_MAX_LBA 8'h04
`define FMT_REG_MAX_CYL 8'h08
`define FMT_REG_MAX_HEAD 8'h0c
`define FMT_REG_MAX_SECT 8'h10
`define FMT_REG_MAX_BFI 8'h14
`define FMT_REG_STATUS 8'h18
`define FMT_REG_DESC_CNT 8'h1c
`define FMT_REG_PI_INT 8'h20
`define FMT_RST_BLK_LEN 16'h0200
`define FMT_RST_MAX_LBA 32'h0000ffff
`define FMT_RST_MAX_CYL 24'h0003ff
`define FMT_RST_MAX_HEAD 8'h07
`define FMT_RST_MAX_SECT 32'h000003ff
`define FMT_RST_MAX_BFI 32'h0007ffff
`define FMT_ST_DEFERRED_BIT 0
`define FMT_ST_CHECK_BIT 1
`define FMT_ST_BUSY_BIT 2
`define FMT_HDR_IGN_PLIST_BIT 6
`define FMT_HDR_PAT_PRESENT_BIT 3
`define FMT_HDR_DSP_BIT 2
`define FMT_HDR_IMMED_BIT 1
`define FMT_PAT_SI_BIT 29
`define FMT_LIST_BLOCK 3'h0
`define FMT_LIST_BFI 3'h4
`define FMT_LIST_PHYS 3'h5
`define FMT_MAX_DESC 16'h0400
`define FMT_PAT_DEPTH 4096
`define FMT_PAT_AW 12
`define FMT_BLK_4K 16'h1000
`define FMT_EXP_4K 4'h3
`define FMT_DEFAULT_PATTERN 8'ha5
`define FMT_SK_ILLEGAL 4'h5
`define FMT_SK_MEDIUM 4'h3
`define FMT_ASC_INV_PARAM 8'h26
`define FMT_ASC_FMT_FAIL 8'h31
`endif

// ==== fmt_chk_pkg.sv ====
package fmt_chk_pkg;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_HDR = 7'h02,
    S_PHDR = 7'h04,
    S_PDAT = 7'h08,
    S_DESC = 7'h10,
    S_QRY = 7'h20,
    S_RUN = 7'h40
  } parse_state_e;
endpackage

// ==== format_param_list_checker.sv ====
// Operation
// - secure initialize set formats every sector, else only accessible ones.
// - pattern type 0 uses built-in pattern, type 1 repeats supplied pattern.
// - type 0 with non-zero length ends with invalid field check condition.
// - type 1 with zero length ends with invalid field check condition.
// - disable-saving clear saves mode parameters during format, set does not.
// - early-status set returns status after transfer, else at format end.
// - early-status format that later fails raises deferred error sense.
// - protection info field zero; type 1 needs exponent zero.
// - type 2/3 interval is block length shifted right by exponent.
// - exponent 3 only with 4096-byte blocks; exponent 0 always.
// - defect list length counts only descriptors; at most 1024 descriptors.
// - list length four or eight times descriptor count, else check.
// - descriptors accepted in any order.
// - descriptor outside user media ends with invalid field check.
// - block format: four-byte LBA, most significant byte first.
// - bytes-from-index: cylinder, head, four-byte offset; sector marked defective.
// - physical sector: cylinder, head, four-byte sector number.
// - ignore-primary set: factory-list matches not added to grown list.
// - descriptors arrive only when the format-data flag is set.
// - pattern descriptor expected only when pattern-present set, else zero fill.
// - ignore-primary set: factory list unused for defects but kept.
//
// Strobed register access and the address map were chosen for this implementation.
`include "fmt_chk_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module format_param_list_checker (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic cmd_start,
  input wire logic format_data_flag,
  input wire logic [2:0] list_format,
  input wire logic [1:0] prot_type,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  output logic query_valid,
  output logic [2:0] query_format,
  output logic [23:0] query_cyl,
  output logic [7:0] query_head,
  output logic [31:0] query_addr,
  input wire logic plist_match,
  output logic glist_add,
  output logic format_go,
  input wire logic format_end,
  input wire logic format_fail,
  output logic done,
  output logic early_status,
  output logic check_cond,
  output logic [3:0] sense_key,
  output logic [7:0] sense_asc,
  output logic deferred_err,
  output logic save_params,
  output logic secure_init,
  output logic use_plist,
  output logic zero_fill,
  output logic default_pattern,
  output logic [15:0] pi_interval,
  input wire logic fill_block_start,
  input wire logic fill_next,
  output logic [7:0] fill_byte
);
  fmt_chk_pkg::parse_state_e st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt, dll_r, dll_nxt, plen_r, plen_nxt, left_r, left_nxt;
  logic [55:0] sh_r, sh_nxt;
  logic [3:0] step_r, step_nxt;
  logic ign_pl_r, ign_pl_nxt, immed_r, immed_nxt;
  logic [15:0] ndesc_r, ndesc_nxt;
  logic qv_r, qv_nxt, ga_r, ga_nxt, go_r, go_nxt, done_r, done_nxt, early_r, early_nxt;
  logic cc_r, cc_nxt, def_r, def_nxt, sp_r, sp_nxt, si_r, si_nxt, up_r, up_nxt;
  logic zf_r, zf_nxt, dp_r, dp_nxt;
  logic [2:0] qf_r, qf_nxt;
  logic [23:0] qc_r, qc_nxt;
  logic [7:0] qh_r, qh_nxt, asc_r, asc_nxt;
  logic [31:0] qa_r, qa_nxt;
  logic [3:0] sk_r, sk_nxt;
  logic [15:0] pii_r, pii_nxt;
  logic [15:0] blk_r, blk_nxt;
  logic [31:0] mlba_r, mlba_nxt, msect_r, msect_nxt, mbfi_r, mbfi_nxt, rd_r, rd_nxt;
  logic [23:0] mcyl_r, mcyl_nxt;
  logic [7:0] mhead_r, mhead_nxt;
  logic [`FMT_PAT_AW-1:0] pidx_r, pidx_nxt;
  logic [7:0] fill_r, fill_nxt;
  logic [7:0] pat_mem [0:`FMT_PAT_DEPTH-1];
  logic [7:0] pat_q;
  logic mem_we;
  logic take;
  logic [31:0] w4;
  logic [63:0] w8;
  logic hdr_bad, pat_bad, desc_bad, desc_last;
  assign take = byte_valid && byte_ready;
  assign w4 = {sh_r[23:0], byte_data};
  assign w8 = {sh_r, byte_data};
  always_comb begin
    hdr_bad = 1'b0;
    if (w4[31:28] != 4'h0) begin
      hdr_bad = 1'b1;
    end
    if (prot_type == 2'h1 && w4[27:24] != 4'h0) begin
      hdr_bad = 1'b1;
    end
    if (prot_type[1] && w4[27:24] != 4'h0 && !(w4[27:24] == `FMT_EXP_4K && blk_r == `FMT_BLK_4K)) begin
      hdr_bad = 1'b1;
    end
    if (list_format == `FMT_LIST_BLOCK) begin
      if (w4[1:0] != 2'h0 || w4[15:0] > (`FMT_MAX_DESC << 2)) begin
        hdr_bad = 1'b1;
      end
    end else if (list_format == `FMT_LIST_BFI || list_format == `FMT_LIST_PHYS) begin
      if (w4[2:0] != 3'h0 || w4[15:0] > (`FMT_MAX_DESC << 3)) begin
        hdr_bad = 1'b1;
      end
    end else if (w4[15:0] != 16'h0) begin
      hdr_bad = 1'b1;
    end
    pat_bad = (w4[31:30] != 2'h0) || (w4[23:16] > 8'h01);
    if (w4[23:16] == 8'h00 && w4[15:0] != 16'h0) begin
      pat_bad = 1'b1;
    end
    if (w4[23:16] == 8'h01 && (w4[15:0] == 16'h0 || w4[15:0] > blk_r)) begin
      pat_bad = 1'b1;
    end
    // range only; no ordering check between descriptors
    if (step_r == 4'h4) begin
      desc_bad = w4 > mlba_r;
    end else begin
      desc_bad = (w8[63:40] > mcyl_r) || (w8[39:32] > mhead_r) ||
        (w8[31:0] > (list_format == `FMT_LIST_BFI ? mbfi_r : msect_r));
    end
    desc_last = cnt_r == {12'h0, step_r} - 16'h1;
  end
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    dll_nxt = dll_r;
    plen_nxt = plen_r;
    left_nxt = left_r;
    sh_nxt = sh_r;
    step_nxt = step_r;
    ign_pl_nxt = ign_pl_r;
    immed_nxt = immed_r;
    ndesc_nxt = ndesc_r;
    qv_nxt = 1'b0;
    ga_nxt = 1'b0;
    go_nxt = 1'b0;
    done_nxt = 1'b0;
    early_nxt = early_r;
    cc_nxt = cc_r;
    sk_nxt = sk_r;
    asc_nxt = asc_r;
    def_nxt = def_r;
    sp_nxt = sp_r;
    si_nxt = si_r;
    up_nxt = up_r;
    zf_nxt = zf_r;
    dp_nxt = dp_r;
    pii_nxt = pii_r;
    qf_nxt = qf_r;
    qc_nxt = qc_r;
    qh_nxt = qh_r;
    qa_nxt = qa_r;
    mem_we = 1'b0;
    if (take) begin
      sh_nxt = w8[55:0];
      cnt_nxt = cnt_r + 16'h1;
    end
    unique case (st_r)
      fmt_chk_pkg::S_IDLE: begin
        if (cmd_start) begin
          cnt_nxt = 16'h0;
          ndesc_nxt = 16'h0;
          cc_nxt = 1'b0;
          sk_nxt = 4'h0;
          asc_nxt = 8'h0;
          early_nxt = 1'b0;
          step_nxt = list_format == `FMT_LIST_BLOCK ? 4'h4 : 4'h8;
          // no data out phase: defaults, zero fill, factory list in use
          if (format_data_flag) begin
            st_nxt = fmt_chk_pkg::S_HDR;
          end else begin
            sp_nxt = 1'b1;
            si_nxt = 1'b0;
            up_nxt = 1'b1;
            zf_nxt = 1'b1;
            dp_nxt = 1'b0;
            immed_nxt = 1'b0;
            pii_nxt = blk_r;
            go_nxt = 1'b1;
            st_nxt = fmt_chk_pkg::S_RUN;
          end
        end
      end
      fmt_chk_pkg::S_HDR: begin
        if (take && cnt_r == 16'h3) begin
          cnt_nxt = 16'h0;
          ign_pl_nxt = w4[16 + `FMT_HDR_IGN_PLIST_BIT];
          up_nxt = !w4[16 + `FMT_HDR_IGN_PLIST_BIT];
          sp_nxt = !w4[16 + `FMT_HDR_DSP_BIT];
          immed_nxt = w4[16 + `FMT_HDR_IMMED_BIT];
          zf_nxt = !w4[16 + `FMT_HDR_PAT_PRESENT_BIT];
          dp_nxt = 1'b0;
          si_nxt = 1'b0;
          dll_nxt = w4[15:0];
          left_nxt = w4[15:0];
          pii_nxt = prot_type[1] ? (blk_r >> w4[27:24]) : blk_r;
          if (hdr_bad) begin
            st_nxt = fmt_chk_pkg::S_IDLE;
          end else if (w4[16 + `FMT_HDR_PAT_PRESENT_BIT]) begin
            st_nxt = fmt_chk_pkg::S_PHDR;
          end else if (w4[15:0] != 16'h0) begin
            st_nxt = fmt_chk_pkg::S_DESC;
          end else begin
            st_nxt = fmt_chk_pkg::S_RUN;
          end
        end
      end
      fmt_chk_pkg::S_PHDR: begin
        if (take && cnt_r == 16'h3) begin
          cnt_nxt = 16'h0;
          si_nxt = w4[`FMT_PAT_SI_BIT];
          dp_nxt = w4[23:16] == 8'h00;
          plen_nxt = w4[15:0];
          if (pat_bad) begin
            st_nxt = fmt_chk_pkg::S_IDLE;
          end else if (w4[23:16] == 8'h01) begin
            st_nxt = fmt_chk_pkg::S_PDAT;
          end else if (dll_r != 16'h0) begin
            st_nxt = fmt_chk_pkg::S_DESC;
          end else begin
            st_nxt = fmt_chk_pkg::S_RUN;
          end
        end
      end
      fmt_chk_pkg::S_PDAT: begin
        mem_we = take;
        if (take && cnt_r == plen_r - 16'h1) begin
          cnt_nxt = 16'h0;
          st_nxt = dll_r != 16'h0 ? fmt_chk_pkg::S_DESC : fmt_chk_pkg::S_RUN;
        end
      end
      fmt_chk_pkg::S_DESC: begin
        if (take && desc_last) begin
          cnt_nxt = 16'h0;
          left_nxt = left_r - {12'h0, step_r};
          qf_nxt = list_format;
          if (step_r == 4'h4) begin
            qc_nxt = 24'h0;
            qh_nxt = 8'h0;
            qa_nxt = w4;
          end else begin
            qc_nxt = w8[63:40];
            qh_nxt = w8[39:32];
            qa_nxt = w8[31:0];
          end
          if (desc_bad) begin
            st_nxt = fmt_chk_pkg::S_IDLE;
          end else begin
            qv_nxt = 1'b1;
            st_nxt = fmt_chk_pkg::S_QRY;
          end
        end
      end
      fmt_chk_pkg::S_QRY: begin
        ga_nxt = !(ign_pl_r && plist_match);
        ndesc_nxt = ndesc_r + 16'h1;
        st_nxt = left_r == 16'h0 ? fmt_chk_pkg::S_RUN : fmt_chk_pkg::S_DESC;
      end
      fmt_chk_pkg::S_RUN: begin
        if (format_end) begin
          st_nxt = fmt_chk_pkg::S_IDLE;
          if (!immed_r) begin
            done_nxt = 1'b1;
            cc_nxt = format_fail;
            sk_nxt = format_fail ? `FMT_SK_MEDIUM : 4'h0;
            asc_nxt = format_fail ? `FMT_ASC_FMT_FAIL : 8'h0;
          end
        end
      end
      default: begin
        st_nxt = fmt_chk_pkg::S_IDLE;
      end
    endcase
    // a parse error ends the command at once; later bytes are refused
    if (st_nxt == fmt_chk_pkg::S_IDLE && st_r != fmt_chk_pkg::S_IDLE && st_r != fmt_chk_pkg::S_RUN) begin
      done_nxt = 1'b1;
      cc_nxt = 1'b1;
      sk_nxt = `FMT_SK_ILLEGAL;
      asc_nxt = `FMT_ASC_INV_PARAM;
    end
    if (st_nxt == fmt_chk_pkg::S_RUN && st_r != fmt_chk_pkg::S_RUN && st_r != fmt_chk_pkg::S_IDLE) begin
      go_nxt = 1'b1;
      if (immed_nxt) begin
        done_nxt = 1'b1;
        early_nxt = 1'b1;
      end
    end
    if (reg_wr && reg_addr == `FMT_REG_STATUS && reg_wdata[`FMT_ST_DEFERRED_BIT]) begin
      def_nxt = 1'b0;
    end
    // set wins over a same-cycle software clear
    if (st_r == fmt_chk_pkg::S_RUN && format_end && format_fail && immed_r) begin
      def_nxt = 1'b1;
    end
  end
  always_comb begin
    blk_nxt = blk_r;
    mlba_nxt = mlba_r;
    mcyl_nxt = mcyl_r;
    mhead_nxt = mhead_r;
    msect_nxt = msect_r;
    mbfi_nxt = mbfi_r;
    rd_nxt = 32'h0;
    if (reg_wr) begin
      unique case (reg_addr)
        `FMT_REG_BLK_LEN: blk_nxt = reg_wdata[15:0];
        `FMT_REG_MAX_LBA: mlba_nxt = reg_wdata;
        `FMT_REG_MAX_CYL: mcyl_nxt = reg_wdata[23:0];
        `FMT_REG_MAX_HEAD: mhead_nxt = reg_wdata[7:0];
        `FMT_REG_MAX_SECT: msect_nxt = reg_wdata;
        `FMT_REG_MAX_BFI: mbfi_nxt = reg_wdata;
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `FMT_REG_BLK_LEN: rd_nxt = {16'h0, blk_r};
        `FMT_REG_MAX_LBA: rd_nxt = mlba_r;
        `FMT_REG_MAX_CYL: rd_nxt = {8'h0, mcyl_r};
        `FMT_REG_MAX_HEAD: rd_nxt = {24'h0, mhead_r};
        `FMT_REG_MAX_SECT: rd_nxt = msect_r;
        `FMT_REG_MAX_BFI: rd_nxt = mbfi_r;
        `FMT_REG_STATUS: rd_nxt = {29'h0, st_r != fmt_chk_pkg::S_IDLE, cc_r, def_r};
        `FMT_REG_DESC_CNT: rd_nxt = {16'h0, ndesc_r};
        `FMT_REG_PI_INT: rd_nxt = {16'h0, pii_r};
        default: rd_nxt = 32'h0;
      endcase
    end
  end
  always_comb begin
    pidx_nxt = pidx_r;
    if (fill_block_start) begin
      pidx_nxt = '0;
    end else if (fill_next) begin
      // wrap at pattern end; block restart cuts the last copy short
      pidx_nxt = ({4'h0, pidx_r} + 16'h1 >= plen_r) ? '0 : pidx_r + 1'b1;
    end
    if (zf_r) begin
      fill_nxt = 8'h00;
    end else if (dp_r) begin
      fill_nxt = `FMT_DEFAULT_PATTERN;
    end else begin
      fill_nxt = pat_q;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      pat_mem[cnt_r[`FMT_PAT_AW-1:0]] <= byte_data;
    end
    pat_q <= pat_mem[pidx_nxt];
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= fmt_chk_pkg::S_IDLE;
      {cnt_r, dll_r, plen_r, left_r, ndesc_r, pii_r} <= '0;
      sh_r <= '0;
      step_r <= 4'h4;
      {ign_pl_r, immed_r, qv_r, ga_r, go_r, done_r, early_r, cc_r, def_r} <= '0;
      {sp_r, si_r, up_r, zf_r, dp_r} <= 5'h16;
      {qf_r, qc_r, qh_r, qa_r, sk_r, asc_r} <= '0;
      blk_r <= `FMT_RST_BLK_LEN;
      mlba_r <= `FMT_RST_MAX_LBA;
      mcyl_r <= `FMT_RST_MAX_CYL;
      mhead_r <= `FMT_RST_MAX_HEAD;
      msect_r <= `FMT_RST_MAX_SECT;
      mbfi_r <= `FMT_RST_MAX_BFI;
      rd_r <= 32'h0;
      pidx_r <= '0;
      fill_r <= 8'h0;
      byte_ready <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      dll_r <= dll_nxt;
      plen_r <= plen_nxt;
      left_r <= left_nxt;
      ndesc_r <= ndesc_nxt;
      pii_r <= pii_nxt;
      sh_r <= sh_nxt;
      step_r <= step_nxt;
      {ign_pl_r, immed_r, qv_r, ga_r, go_r} <= {ign_pl_nxt, immed_nxt, qv_nxt, ga_nxt, go_nxt};
      {done_r, early_r, cc_r, def_r} <= {done_nxt, early_nxt, cc_nxt, def_nxt};
      {sp_r, si_r, up_r, zf_r, dp_r} <= {sp_nxt, si_nxt, up_nxt, zf_nxt, dp_nxt};
      {qf_r, qc_r, qh_r, qa_r, sk_r, asc_r} <= {qf_nxt, qc_nxt, qh_nxt, qa_nxt, sk_nxt, asc_nxt};
      blk_r <= blk_nxt;
      mlba_r <= mlba_nxt;
      mcyl_r <= mcyl_nxt;
      mhead_r <= mhead_nxt;
      msect_r <= msect_nxt;
      mbfi_r <= mbfi_nxt;
      rd_r <= rd_nxt;
      pidx_r <= pidx_nxt;
      fill_r <= fill_nxt;
      byte_ready <= st_nxt == fmt_chk_pkg::S_HDR || st_nxt == fmt_chk_pkg::S_PHDR ||
        st_nxt == fmt_chk_pkg::S_PDAT || st_nxt == fmt_chk_pkg::S_DESC;
    end
  end
  assign reg_rdata = rd_r;
  assign {query_valid, query_format, query_cyl, query_head, query_addr} = {qv_r, qf_r, qc_r, qh_r, qa_r};
  assign {glist_add, format_go, done, early_status, check_cond} = {ga_r, go_r, done_r, early_r, cc_r};
  assign {sense_key, sense_asc, deferred_err} = {sk_r, asc_r, def_r};
  assign {save_params, secure_init, use_plist, zero_fill, default_pattern} = {sp_r, si_r, up_r, zf_r, dp_r};
  assign pi_interval = pii_r;
  assign fill_byte = fill_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  chk_type0_len: assert property (
    st_r == fmt_chk_pkg::S_PHDR && take && cnt_r == 16'h3 && w4[23:16] == 8'h00 && w4[15:0] != 16'h0
    |=> done && check_cond && sense_asc == `FMT_ASC_INV_PARAM) else $error("type 0 length not rejected");
  chk_type1_len: assert property (
    st_r == fmt_chk_pkg::S_PHDR && take && cnt_r == 16'h3 && w4[23:16] == 8'h01 && w4[15:0] == 16'h0
    |=> done && check_cond && sense_key == `FMT_SK_ILLEGAL) else $error("type 1 zero length not rejected");
  chk_exp_type1: assert property (
    st_r == fmt_chk_pkg::S_HDR && take && cnt_r == 16'h3 && prot_type == 2'h1 && w4[27:24] != 4'h0
    |=> done && check_cond) else $error("type 1 exponent not rejected");
  chk_pi_interval: assert property (
    st_r == fmt_chk_pkg::S_HDR && take && cnt_r == 16'h3 && !hdr_bad && prot_type[1]
    |=> pi_interval == ($past(blk_r) >> $past(w4[27:24]))) else $error("interval wrong");
  chk_save_flag: assert property (
    st_r == fmt_chk_pkg::S_HDR && take && cnt_r == 16'h3
    |=> save_params == !$past(w4[16 + `FMT_HDR_DSP_BIT])) else $error("save flag wrong");
  chk_early_done: assert property (
    format_go && immed_r |-> done && early_status) else $error("early status missing");
  chk_late_done: assert property (
    st_r == fmt_chk_pkg::S_RUN && format_end && !immed_r |=> done ##1 !done) else $error("late status missing");
  chk_deferred: assert property (
    st_r == fmt_chk_pkg::S_RUN && format_end && format_fail && immed_r |=> deferred_err [*2])
    else $error("deferred error lost");
  chk_plist_skip: assert property (
    st_r == fmt_chk_pkg::S_QRY && ign_pl_r && plist_match |=> !glist_add) else $error("factory match added");
  chk_query_once: assert property (
    query_valid |-> ##1 !query_valid ##1 !query_valid) else $error("query not one pulse");
endmodule
`default_nettype wire

// ==== initiator_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module initiator_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  // message armed by the bench; large enough for an over-long defect list
  logic [7:0] msg [0:4199];
  int msg_len = 0;
  int idx = 0;

  // each byte is held until taken; a released line shows the inverse, not the last value
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
    end else if (byte_valid && byte_ready) begin
      idx <= idx + 1;
      byte_valid <= (idx + 1 < msg_len);
      byte_data <= (idx + 1 < msg_len) ? msg[idx + 1] : ~byte_data;
    end else if (idx < msg_len) begin
      byte_valid <= 1'b1;
      byte_data <= msg[idx];
    end else if (byte_valid) begin
      byte_valid <= 1'b0;
      byte_data <= ~byte_data;
    end
  end
endmodule
`default_nettype wire

// ==== test_format_param_list_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_format_param_list_checker;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, cmd_start = 1'b0, format_data_flag = 1'b0;
  logic [2:0] list_format = 3'h0;
  logic [1:0] prot_type = 2'h0;
  logic plist_match = 1'b0, format_end = 1'b0, format_fail = 1'b0;
  logic fill_block_start = 1'b0, fill_next = 1'b0;
  logic byte_valid, byte_ready, query_valid, glist_add, format_go, done, early_status, check_cond;
  logic deferred_err, save_params, secure_init, use_plist, zero_fill, default_pattern;
  logic [7:0] byte_data, query_head, sense_asc, fill_byte;
  logic [2:0] query_format, q_fmt;
  logic [23:0] query_cyl, q_cyl;
  logic [31:0] reg_rdata, query_addr, q_addr, d;
  logic [3:0] sense_key;
  logic [15:0] pi_interval;
  logic [7:0] q_head;
  int mismatches = 0, checks = 0, n = 0, dones = 0, adds = 0, gos = 0, cyc = 0;

  format_param_list_checker i_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_start(cmd_start), .format_data_flag(format_data_flag), .list_format(list_format),
    .prot_type(prot_type), .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
    .query_valid(query_valid), .query_format(query_format), .query_cyl(query_cyl),
    .query_head(query_head), .query_addr(query_addr), .plist_match(plist_match),
    .glist_add(glist_add), .format_go(format_go), .format_end(format_end),
    .format_fail(format_fail), .done(done), .early_status(early_status), .check_cond(check_cond),
    .sense_key(sense_key), .sense_asc(sense_asc), .deferred_err(deferred_err),
    .save_params(save_params), .secure_init(secure_init), .use_plist(use_plist),
    .zero_fill(zero_fill), .default_pattern(default_pattern), .pi_interval(pi_interval),
    .fill_block_start(fill_block_start), .fill_next(fill_next), .fill_byte(fill_byte));

  initiator_model i_init (.sys_clk(sys_clk), .resetn(resetn), .byte_ready(byte_ready),
    .byte_valid(byte_valid), .byte_data(byte_data));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  // engine model answers one cycle after go; pulses captured where they stand
  always @(posedge sys_clk) begin
    format_end <= format_go;
    cyc <= cyc + 1;
    if (query_valid) begin
      q_fmt <= query_format;
      q_cyl <= query_cyl;
      q_head <= query_head;
      q_addr <= query_addr;
    end
    if (glist_add) adds <= adds + 1;
    if (format_go) gos <= gos + 1;
    if (done) dones <= dones + 1;
    if (cyc == 30000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // appends nb bytes of v, most significant first
  task automatic put(input logic [31:0] v, input int nb);
    for (int i = nb - 1; i >= 0; i--) begin
      i_init.msg[n] = v[8*i +: 8];
      n++;
    end
  endtask

  task automatic go(input logic fd, input logic [2:0] lf, input logic [1:0] pt);
    @(posedge sys_clk);
    #1;
    i_init.idx = 0;
    i_init.msg_len = n;
    dones = 0;
    adds = 0;
    gos = 0;
    @(posedge sys_clk);
    cmd_start <= 1'b1;
    format_data_flag <= fd;
    list_format <= lf;
    prot_type <= pt;
    @(posedge sys_clk);
    cmd_start <= 1'b0;
    for (int k = 0; k < 6000 && dones == 0; k++) @(posedge sys_clk);
    // deferred failure lands a few cycles after early status
    repeat (4) @(posedge sys_clk);
    #1;
    i_init.msg_len = 0;
    n = 0;
    if (dones == 0) chk(32'h0, 32'h1);
  endtask

  task automatic st(input logic e);
    chk(check_cond, e);
    if (e) chk({sense_key, sense_asc}, 12'h526);
  endtask

  // fill byte stands two cycles after the request
  task automatic fl(input logic first, input logic [7:0] e);
    @(posedge sys_clk);
    fill_block_start <= first;
    fill_next <= ~first;
    @(posedge sys_clk);
    fill_block_start <= 1'b0;
    fill_next <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(fill_byte, e);
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(8'h00, d);
    chk(d, 32'h200);
    rd(8'h04, d);
    chk(d, 32'hffff);
    rd(8'h40, d);
    chk(d, 32'h0);
    go(1'b0, 3'h0, 2'h0);
    chk(gos, 1);
    chk(zero_fill, 1);
    // early status, secure init, pattern of three bytes, one block descriptor
    format_fail <= 1'b1;
    put(32'h000a0004, 4);
    put(32'h20010003, 4);
    put(32'h112233, 3);
    put(32'h1234, 4);
    go(1'b1, 3'h0, 2'h0);
    chk(early_status, 1);
    chk(deferred_err, 1);
    chk(secure_init, 1);
    chk(save_params, 1);
    chk({q_fmt, q_addr}, {3'h0, 32'h1234});
    chk(adds, 1);
    fl(1'b1, 8'h11);
    fl(1'b0, 8'h22);
    fl(1'b0, 8'h33);
    fl(1'b0, 8'h11);
    wr(8'h18, 32'h1);
    rd(8'h18, d);
    chk(d[0], 0);
    // status at the end, failure reported; factory hit dropped from the grown list
    plist_match <= 1'b1;
    put(32'h00440008, 4);
    put(32'h00010203, 4);
    put(32'h45, 4);
    go(1'b1, 3'h5, 2'h0);
    chk({q_fmt, q_cyl, q_head, q_addr}, {3'h5, 24'h102, 8'h03, 32'h45});
    chk(adds, 0);
    chk(use_plist, 0);
    chk(save_params, 0);
    chk({early_status, check_cond, sense_key, sense_asc}, {2'b01, 12'h331});
    // descriptors out of order, bytes from index
    plist_match <= 1'b0;
    format_fail <= 1'b0;
    put(32'h10, 4);
    put(32'h00000201, 4);
    put(32'h100, 4);
    put(32'h00000100, 4);
    put(32'h50, 4);
    go(1'b1, 3'h4, 2'h0);
    st(1'b0);
    chk({adds, q_cyl, q_head, q_addr}, {32'd2, 24'h1, 8'h0, 32'h50});
    rd(8'h1c, d);
    chk(d, 32'h2);
    put(32'h00080000, 4);
    put(32'h0, 4);
    go(1'b1, 3'h0, 2'h0);
    chk(default_pattern, 1);
    fl(1'b1, 8'ha5);
    // refused parameter lists; 1024 descriptors accepted, 1025 refused
    put(32'h00080000, 4);
    put(32'h00000002, 4);
    put(32'h0101, 2);
    go(1'b1, 3'h0, 2'h0);
    st(1'b1);
    put(32'h00080000, 4);
    put(32'h00010000, 4);
    go(1'b1, 3'h0, 2'h0);
    st(1'b1);
    put(32'h6, 4);
    put(32'h0, 4);
    put(32'h0, 2);
    go(1'b1, 3'h0, 2'h0);
    st(1'b1);
    put(32'h4, 4);
    put(32'h10000, 4);
    go(1'b1, 3'h0, 2'h0);
    st(1'b1);
    put(32'h01000000, 4);
    go(1'b1, 3'h0, 2'h1);
    st(1'b1);
    put(32'h03000000, 4);
    go(1'b1, 3'h0, 2'h2);
    st(1'b1);
    for (int c = 1024; c <= 1025; c++) begin
      put(c * 4, 4);
      repeat (c) put(32'h0, 4);
      go(1'b1, 3'h0, 2'h0);
      st(c > 1024);
    end
    // protection interval on 4096-byte blocks
    wr(8'h00, 32'h1000);
    put(32'h03000000, 4);
    go(1'b1, 3'h0, 2'h2);
    st(1'b0);
    chk(pi_interval, 16'h200);
    rd(8'h20, d);
    chk(d, 32'h200);
    put(32'h0, 4);
    go(1'b1, 3'h0, 2'h3);
    chk(pi_interval, 16'h1000);
    print_verdict();
  end
endmodule
`default_nettype wire
